// ===== common/pmu_adc_pkg.sv
// Notes on behaviour
// (RULE1) A 12-bit converter serves eight sources: charge current, discharge current, battery, backup cell, charger input, system supply, die temperature and an external pin.
// (RULE2) Conversion timing comes from a 4 MHz converter clock, never from the register port clock; the code derives the 4 MHz tick from the port clock.
// (RULE3) A valid result stands in the two result registers within 3 ms of a trigger, and the host waits that long before trusting them.
// (RULE4) The converter goes into power save by itself whenever no conversion runs and wakes when a new one is triggered.
// (RULE5) Every write of a one to the conversion trigger bit starts a fresh conversion on the source selected at that moment.
// (RULE6) The result is split over two read-only registers and its eight top bits come with one read.
// (RULE7) The read-write control register holds the trigger, the source select field and the format select.
// (RULE8) With the format bit at one the result loses its top bit and the rest moves up one place.
// (RULE9) Source code 0011 routes the battery voltage, full scale 4.80 V at code 4095.
// (RULE10) The die temperature reading is 390 degrees C at code zero and falls by 0.16 degrees C per code.
// (RULE11) The discharge current sense full scale is chosen in register 0x19 so that code 4095 matches the wanted maximum current.
// (RULE12) The result registers hold the last finished conversion until the next one finishes.
package pmu_adc_pkg;

  // register offsets
  localparam logic [7:0] SENSE_FS_ADDR = 8'h19;
  localparam logic [7:0] CTRL_ADDR = 8'h87;
  localparam logic [7:0] RES_HI_ADDR = 8'h88;
  localparam logic [7:0] RES_LO_ADDR = 8'h89;

  // control register fields
  localparam int CTRL_TRIG_BIT = 7;
  localparam int CTRL_FRESH_BIT = 6;
  localparam int CTRL_TMO_BIT = 5;
  localparam int CTRL_FMT_BIT = 4;
  localparam int CTRL_SRC_LSB = 0;
  localparam int SRC_W = 4;

  // result layout
  localparam int RES_W = 12;
  localparam int RES_HI_LSB = 4;
  localparam logic [3:0] RES_LO_PAD = 4'h0;

  // reset values
  localparam logic [7:0] SENSE_FS_RESET = 8'h00;
  localparam logic [SRC_W-1:0] SRC_RESET = 4'h0;
  localparam logic [RES_W-1:0] RESULT_RESET = 12'h000;
  localparam logic [RES_W-1:0] SAR_MSB_ONLY = 12'h800;

  // clock rates and conversion time
  localparam int SYS_CLK_KHZ = 125000;
  localparam int ADC_CLK_KHZ = 4000;
  localparam int CONV_TIME_US = 3000;
  localparam int CONV_TICKS = CONV_TIME_US * ADC_CLK_KHZ / 1000;
  localparam int CONV_CYCLES = CONV_TIME_US * SYS_CLK_KHZ / 1000;
  localparam int SAR_MARGIN_TICKS = 16;
  localparam int SETTLE_TICKS = CONV_TICKS - SAR_MARGIN_TICKS;

  // fractional divider: add the converter rate, wrap at the system rate (units of MHz)
  localparam logic [7:0] TICK_STEP = 8'(ADC_CLK_KHZ / 1000);
  localparam logic [7:0] TICK_MOD = 8'(SYS_CLK_KHZ / 1000);

  // scaling of readings, for software
  localparam logic [RES_W-1:0] FULL_CODE = 12'hFFF;
  localparam int BATTERY_SENSE_PIN_FS_MV = 4800;
  localparam int TEMP_ZERO_CENTI_C = 39000; // [RULE10]
  localparam int TEMP_STEP_CENTI_C = 16;

  // input multiplexer codes
  typedef enum logic [SRC_W-1:0] {
    SRC_CHG_CURRENT = 4'h0,
    SRC_DISCHG_CURRENT = 4'h1,
    SRC_CHARGER_IN = 4'h2,
    SRC_BATTERY = 4'h3,
    SRC_BACKUP_CELL = 4'h4,
    SRC_SYS_SUPPLY = 4'h5,
    SRC_DIE_TEMP = 4'h6,
    SRC_EXT_PIN = 4'h7
  } adc_source_t;

endpackage

// ===== common/sar_if.sv
`timescale 1ns/1ps
// links the control logic, the converter clock divider and the approximation engine
interface sar_if;
  logic tick;
  logic start;
  logic abort;
  logic busy;
  logic done;
  logic cmp;
  logic [pmu_adc_pkg::RES_W-1:0] result;
  logic [pmu_adc_pkg::RES_W-1:0] dac;

  modport ctrl (output start, output abort, output cmp, input tick, input busy, input done, input result, input dac);
  modport engine (input tick, input start, input abort, input cmp, output busy, output done, output result, output dac);
  modport timebase (output tick);
endinterface

// ===== testbench/analog_level_model.sv
`timescale 1ns/1ps
// analog input seen through the comparator: high while level is at or above the trial code
module analog_level_model (
  input wire logic [11:0] dac_code_i,
  input wire logic [11:0] level_i,
  output logic cmp_o
);
  assign cmp_o = level_i >= dac_code_i;
endmodule // analog_level_model

// ===== testbench/pmu_adc_sva.sv
`timescale 1ns/1ps
// watches the register port and converter state
module pmu_adc_sva #(
  parameter int settle_ticks = pmu_adc_pkg::SETTLE_TICKS,
  parameter int conv_cycles = pmu_adc_pkg::CONV_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic cmp_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [pmu_adc_pkg::RES_W-1:0] dac_code_o,
  input wire logic [pmu_adc_pkg::SRC_W-1:0] src_sel_o,
  input wire logic [7:0] sense_fs_o,
  input wire logic converter_sleep_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  logic trig_w;
  logic [31:0] awake_q;
  // control write with the trigger bit set
  assign trig_w = reg_wr_i && reg_addr_i == pmu_adc_pkg::CTRL_ADDR && reg_wdata_i[pmu_adc_pkg::CTRL_TRIG_BIT];
  // cycles awake since the last trigger
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      awake_q <= '0;
    end
    else if (trig_w || converter_sleep_o)
    begin
      awake_q <= '0;
    end
    else
    begin
      awake_q <= awake_q + 32'h00000001;
    end
  end
  sequence trig_s;
    trig_w;
  endsequence
  sequence wake_s;
    !converter_sleep_o;
  endsequence
  chk_trig_wakes: assert property (trig_s |=> wake_s) else $error("no wake");
  chk_src_latch: assert property (trig_s |=> src_sel_o == $past(reg_wdata_i[3:0])) else $error("src");
  chk_wake_cause: assert property ($fell(converter_sleep_o) |-> $past(trig_w)) else $error("wake");
  chk_src_hold: assert property (wake_s and !trig_w |=> $stable(src_sel_o)) else $error("src moved");
  chk_conv_bound: assert property (awake_q <= conv_cycles + 2) else $error("too long");
  chk_sense_write: assert property (reg_wr_i && reg_addr_i == pmu_adc_pkg::SENSE_FS_ADDR
    |=> sense_fs_o == $past(reg_wdata_i)) else $error("sense");
  chk_low_pad: assert property (reg_addr_i == pmu_adc_pkg::RES_LO_ADDR
    |=> reg_rdata_o[3:0] == pmu_adc_pkg::RES_LO_PAD) else $error("pad");
  chk_unmapped_zero: assert property (!(reg_addr_i inside {8'h19, 8'h87, 8'h88, 8'h89})
    |=> reg_rdata_o == 8'h00) else $error("unmapped");
  chk_busy_flag: assert property (reg_addr_i == pmu_adc_pkg::CTRL_ADDR
    |=> reg_rdata_o[7] == !$past(converter_sleep_o)) else $error("busy");
endmodule // pmu_adc_sva
bind pmu_adc_conversion_control pmu_adc_sva #(.settle_ticks(settle_ticks), .conv_cycles(conv_cycles)) u_pmu_adc_sva (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .cmp_i(cmp_i), .reg_rdata_o(reg_rdata_o),
  .dac_code_o(dac_code_o), .src_sel_o(src_sel_o), .sense_fs_o(sense_fs_o),
  .converter_sleep_o(converter_sleep_o));

// ===== testbench/tb_pmu_adc_conversion_control.sv
`timescale 1ns/1ps
// drives the register port, checks read data against queued expectations
module tb_pmu_adc_conversion_control;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic cmp_i;
  logic [7:0] reg_rdata_o;
  logic [11:0] dac_code_o;
  logic [3:0] src_sel_o;
  logic [7:0] sense_fs_o;
  logic converter_sleep_o;
  logic [11:0] level = 12'h000;
  logic [7:0] v;
  logic rd_pend = 1'b0;
  logic [7:0] exp_q[$];
  int mismatches = 0;
  int check_count = 0;
  int seed = 18993;
  int cycles = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  pmu_adc_conversion_control #(.settle_ticks(4), .conv_cycles(2000)) u_pmu_adc_conversion_control (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .cmp_i(cmp_i), .reg_rdata_o(reg_rdata_o),
    .dac_code_o(dac_code_o), .src_sel_o(src_sel_o), .sense_fs_o(sense_fs_o),
    .converter_sleep_o(converter_sleep_o));
  analog_level_model u_analog_level_model (.dac_code_i(dac_code_o), .level_i(level), .cmp_o(cmp_i));
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge sys_clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    exp_q.push_back(e);
    @(negedge sys_clk_i);
    reg_rd_i = 1'b0;
  endtask
  // bounded wait for the converter to fall asleep
  task automatic wait_idle;
    int n;
    n = 0;
    @(negedge sys_clk_i);
    while (converter_sleep_o !== 1'b1 && n < 3000)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n == 3000)
    begin
      mismatches++;
      conclude();
    end
  endtask
  // one conversion, then flags, both result bytes and a repeat read
  task automatic conv(input logic [3:0] s, input logic f, input logic [11:0] lv);
    logic [11:0] r;
    r = f ? {lv[10:0], 1'b0} : lv;
    @(negedge sys_clk_i);
    level = lv;
    wr(8'h87, {3'b100, f, s});
    rd(8'h87, {3'b100, f, s});
    wait_idle();
    chk({4'h0, src_sel_o}, {4'h0, s});
    chk({7'h00, converter_sleep_o}, 8'h01);
    chk(dac_code_o[11:4], lv[11:4]);
    level = ~lv;
    rd(8'h87, {3'b010, f, s});
    rd(8'h88, r[11:4]);
    rd(8'h89, {r[3:0], 4'h0});
    rd(8'h88, r[11:4]);
    rd(8'h87, {3'b000, f, s});
    $display("test conversion src %h done", s);
  endtask
  // result compare one cycle after each read
  always @(posedge sys_clk_i)
    rd_pend <= reg_rd_i;
  always @(negedge sys_clk_i)
    if (rd_pend && exp_q.size() > 0)
      chk(reg_rdata_o, exp_q.pop_front());
  // hang guard
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      conclude();
    end
  end
  initial
  begin
    repeat (10) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    nrst_i = 1'b1;
    rd(8'h87, 8'h00);
    rd(8'h88, 8'h00);
    rd(8'h89, 8'h00);
    rd(8'h19, 8'h00);
    rd(8'h20, 8'h00);
    v = 8'($random(seed));
    wr(8'h19, v);
    chk(sense_fs_o, v);
    wr(8'h88, 8'hFF);
    rd(8'h19, v);
    rd(8'h88, 8'h00);
    $display("test registers done");
    for (int s = 0; s < 8; s++)
      conv(4'(s), s[0], 12'($random(seed)));
    conv(4'h3, 1'b0, 12'hFFF);
    conv(4'h6, 1'b1, 12'h800);
    conv(4'h6, 1'b0, 12'h9C4);
    wr(8'h87, 8'h85);
    repeat (40) @(negedge sys_clk_i);
    conv(4'h2, 1'b0, 12'h5A3);
    repeat (4) @(negedge sys_clk_i);
    conclude();
  end
endmodule // tb_pmu_adc_conversion_control

// ===== verilog/adc_sar_engine.sv
`timescale 1ns/1ps
// successive approximation: wake and settle, then one bit per converter tick
module adc_sar_engine #(
  parameter int settle_ticks = pmu_adc_pkg::SETTLE_TICKS
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  sar_if.engine sar
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_SETTLE = 3'b010,
    S_CONV = 3'b100
  } sar_phase_t;

  typedef struct packed {
    sar_phase_t phase;
    logic [13:0] cnt;
    logic [3:0] bit_idx;
    logic [pmu_adc_pkg::RES_W-1:0] trial;
    logic [pmu_adc_pkg::RES_W-1:0] result;
    logic done;
  } sar_state_t;

  localparam logic [13:0] SETTLE_LAST = 14'(settle_ticks - 1);
  localparam logic [3:0] TOP_BIT = 4'(pmu_adc_pkg::RES_W - 1);

  sar_state_t q;
  sar_state_t d;
  logic [pmu_adc_pkg::RES_W-1:0] kept;

  // phase sequencing and bit decisions
  always_comb
  begin
    d = q;
    d.done = 1'b0;
    kept = q.trial;
    if (!sar.cmp)
    begin
      kept[q.bit_idx] = 1'b0;
    end
    unique case (q.phase)
      S_IDLE:
      begin
        if (sar.start)
        begin
          d.phase = S_SETTLE; // [RULE4]
          d.cnt = '0;
          d.trial = '0;
        end
      end
      S_SETTLE:
      begin
        if (sar.tick)
        begin
          if (q.cnt == SETTLE_LAST)
          begin
            d.phase = S_CONV;
            d.bit_idx = TOP_BIT;
            d.trial = pmu_adc_pkg::SAR_MSB_ONLY;
          end
          else
          begin
            d.cnt = q.cnt + 14'h0001;
          end
        end
      end
      S_CONV:
      begin
        if (sar.tick)
        begin
          d.trial = kept; // [RULE1]
          if (q.bit_idx == 4'h0)
          begin
            d.result = kept;
            d.done = 1'b1;
            d.phase = S_IDLE; // [RULE4]
          end
          else
          begin
            d.bit_idx = q.bit_idx - 4'h1;
            d.trial[q.bit_idx - 4'h1] = 1'b1;
          end
        end
      end
    endcase
    // a new trigger while running throws the old work away
    if (sar.start && (q.phase != S_IDLE))
    begin
      d.phase = S_SETTLE; // [RULE5]
      d.cnt = '0;
      d.trial = '0;
      d.done = 1'b0;
    end
    if (sar.abort)
    begin
      d.phase = S_IDLE;
      d.done = 1'b0;
    end
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      q <= '{phase: S_IDLE, cnt: '0, bit_idx: '0, trial: '0, result: pmu_adc_pkg::RESULT_RESET, done: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  assign sar.busy = (q.phase != S_IDLE);
  assign sar.done = q.done;
  assign sar.result = q.result;
  assign sar.dac = q.trial;

endmodule // adc_sar_engine

// ===== verilog/adc_tick_gen.sv
`timescale 1ns/1ps
// makes a 4 MHz enable from the 125 MHz clock by phase accumulation
module adc_tick_gen (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  sar_if.timebase tb
);

  typedef struct packed {
    logic [7:0] acc;
    logic tick;
  } tick_state_t;

  tick_state_t q;
  tick_state_t d;
  logic [7:0] sum;

  // average rate is exact, spacing is 31 cycles three times in four and 32 cycles once
  always_comb
  begin
    d = q;
    sum = q.acc + pmu_adc_pkg::TICK_STEP;
    if (sum >= pmu_adc_pkg::TICK_MOD)
    begin
      d.acc = sum - pmu_adc_pkg::TICK_MOD;
      d.tick = 1'b1; // [RULE2]
    end
    else
    begin
      d.acc = sum;
      d.tick = 1'b0;
    end
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign tb.tick = q.tick;

endmodule // adc_tick_gen

// ===== verilog/pmu_adc_conversion_control.sv
`timescale 1ns/1ps
// converter control, result registers and register port of the monitoring converter
module pmu_adc_conversion_control #(
  parameter int settle_ticks = pmu_adc_pkg::SETTLE_TICKS,
  parameter int conv_cycles = pmu_adc_pkg::CONV_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic cmp_i,
  output logic [7:0] reg_rdata_o,
  output logic [pmu_adc_pkg::RES_W-1:0] dac_code_o,
  output logic [pmu_adc_pkg::SRC_W-1:0] src_sel_o,
  output logic [7:0] sense_fs_o,
  output logic converter_sleep_o
);

  typedef struct packed {
    logic [pmu_adc_pkg::SRC_W-1:0] src;
    logic fmt;
    logic [pmu_adc_pkg::SRC_W-1:0] src_active;
    logic fmt_active;
    logic busy;
    logic fresh;
    logic timeout;
    logic start;
    logic abort;
    logic [7:0] sense_fs;
    logic [pmu_adc_pkg::RES_W-1:0] result;
    logic [18:0] wdog;
    logic [7:0] rdata;
    logic sleep;
  } ctrl_state_t;

  localparam logic [18:0] WDOG_LAST = 19'(conv_cycles - 1);

  ctrl_state_t q;
  ctrl_state_t d;
  logic ctrl_wr;
  logic trig_wr;
  logic [7:0] ctrl_view;

  sar_if sar ();

  adc_tick_gen u_tick (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .tb(sar.timebase)
  );

  adc_sar_engine #(
    .settle_ticks(settle_ticks)
  ) u_sar (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .sar(sar.engine)
  );

  // write decode and control readback
  always_comb
  begin
    ctrl_wr = reg_wr_i && (reg_addr_i == pmu_adc_pkg::CTRL_ADDR);
    trig_wr = ctrl_wr && reg_wdata_i[pmu_adc_pkg::CTRL_TRIG_BIT];
    ctrl_view = '0;
    ctrl_view[pmu_adc_pkg::CTRL_TRIG_BIT] = q.busy;
    ctrl_view[pmu_adc_pkg::CTRL_FRESH_BIT] = q.fresh;
    ctrl_view[pmu_adc_pkg::CTRL_TMO_BIT] = q.timeout;
    ctrl_view[pmu_adc_pkg::CTRL_FMT_BIT] = q.fmt;
    ctrl_view[pmu_adc_pkg::CTRL_SRC_LSB +: pmu_adc_pkg::SRC_W] = q.src; // [RULE7]
  end

  // control, conversion bookkeeping and result capture
  always_comb
  begin
    d = q;
    d.start = 1'b0;
    d.abort = 1'b0;
    if (ctrl_wr)
    begin
      d.src = reg_wdata_i[pmu_adc_pkg::CTRL_SRC_LSB +: pmu_adc_pkg::SRC_W]; // [RULE7]
      d.fmt = reg_wdata_i[pmu_adc_pkg::CTRL_FMT_BIT]; // [RULE7]
    end
    if (reg_wr_i && (reg_addr_i == pmu_adc_pkg::SENSE_FS_ADDR))
    begin
      d.sense_fs = reg_wdata_i; // [RULE11]
    end
    // reading the high byte consumes the fresh flag
    if (reg_rd_i && (reg_addr_i == pmu_adc_pkg::RES_HI_ADDR))
    begin
      d.fresh = 1'b0;
    end
    // guard time runs while a conversion is outstanding
    if (q.busy)
    begin
      d.wdog = q.wdog + 19'h00001;
    end
    if (sar.done && q.busy)
    begin
      if (q.fmt_active)
      begin
        d.result = {sar.result[pmu_adc_pkg::RES_W-2:0], 1'b0}; // [RULE8]
      end
      else
      begin
        d.result = sar.result; // [RULE12]
      end
      d.fresh = 1'b1;
      d.busy = 1'b0;
    end
    else if (q.busy && (q.wdog == WDOG_LAST))
    begin
      d.busy = 1'b0; // [RULE3]
      d.timeout = 1'b1;
      d.abort = 1'b1;
    end
    // a trigger always starts over on the source written with it
    if (trig_wr)
    begin
      d.start = 1'b1; // [RULE5]
      d.abort = 1'b0;
      d.busy = 1'b1;
      d.timeout = 1'b0;
      d.wdog = '0;
      d.src_active = reg_wdata_i[pmu_adc_pkg::CTRL_SRC_LSB +: pmu_adc_pkg::SRC_W]; // [RULE9]
      d.fmt_active = reg_wdata_i[pmu_adc_pkg::CTRL_FMT_BIT];
    end
    d.sleep = !d.busy; // [RULE4]
    // registered read data, unmapped offsets read zero
    unique case (reg_addr_i)
      pmu_adc_pkg::SENSE_FS_ADDR: d.rdata = q.sense_fs;
      pmu_adc_pkg::CTRL_ADDR: d.rdata = ctrl_view;
      pmu_adc_pkg::RES_HI_ADDR: d.rdata = q.result[pmu_adc_pkg::RES_W-1:pmu_adc_pkg::RES_HI_LSB]; // [RULE6]
      pmu_adc_pkg::RES_LO_ADDR: d.rdata = {q.result[pmu_adc_pkg::RES_HI_LSB-1:0], pmu_adc_pkg::RES_LO_PAD}; // [RULE6]
      default: d.rdata = 8'h00;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      q <= '{src: pmu_adc_pkg::SRC_RESET, fmt: 1'b0, src_active: pmu_adc_pkg::SRC_RESET, fmt_active: 1'b0,
             busy: 1'b0, fresh: 1'b0, timeout: 1'b0, start: 1'b0, abort: 1'b0,
             sense_fs: pmu_adc_pkg::SENSE_FS_RESET, result: pmu_adc_pkg::RESULT_RESET,
             wdog: '0, rdata: 8'h00, sleep: 1'b1};
    end
    else
    begin
      q <= d;
    end
  end

  // engine hookup and outputs
  assign sar.start = q.start;
  assign sar.abort = q.abort;
  assign sar.cmp = cmp_i;
  assign reg_rdata_o = q.rdata;
  assign dac_code_o = sar.dac;
  assign src_sel_o = q.src_active; // [RULE1]
  assign sense_fs_o = q.sense_fs;
  assign converter_sleep_o = q.sleep;

endmodule // pmu_adc_conversion_control
